// ---- common/evpd_pkg.sv ----
package evpd_pkg;

    // vector low bytes, added to the base page
    localparam logic [7:0]  EVPD_VEC_SPURIOUS_OFS = 8'h80;
    localparam logic [7:0]  EVPD_VEC_I_BASE_OFS   = 8'h82;
    localparam logic [7:0]  EVPD_VEC_I_TOP_OFS    = 8'hF2;
    localparam logic [7:0]  EVPD_VEC_X_OFS        = 8'hF4;
    localparam logic [7:0]  EVPD_VEC_SWI_OFS      = 8'hF6;
    localparam logic [7:0]  EVPD_VEC_TRAP_OFS     = 8'hF8;
    localparam logic [7:0]  EVPD_VEC_LOW_ZERO     = 8'h00;

    // fixed reset vectors
    localparam logic [15:0] EVPD_VEC_RST_POR      = 16'hFFFE;
    localparam logic [15:0] EVPD_VEC_RST_CLKMON   = 16'hFFFC;
    localparam logic [15:0] EVPD_VEC_RST_WDOG     = 16'hFFFA;

    // base page values
    localparam logic [7:0]  EVPD_VBR_RESET        = 8'hFF;
    localparam logic [7:0]  EVPD_VBR_DEBUG        = 8'hFF;

    // device-specific maskable sources below the top slot
    localparam int          EVPD_I_DEV_NUM        = 56;
    localparam int          EVPD_I_NUM            = 57;
    // die-to-die initiator present: selects x and top-slot sources
    localparam logic        EVPD_HAS_D2D          = 1'b1;

    // register byte offsets
    localparam logic [7:0]  EVPD_ADDR_VBR         = 8'h00;
    localparam logic [7:0]  EVPD_ADDR_STATUS      = 8'h04;
    localparam logic [7:0]  EVPD_ADDR_PEND_LO     = 8'h08;
    localparam logic [7:0]  EVPD_ADDR_PEND_HI     = 8'h0C;

    // status register field positions
    localparam int          EVPD_ST_VEC_LSB       = 0;
    localparam int          EVPD_ST_SEEN_BIT      = 16;
    localparam int          EVPD_ST_DEBUG_BIT     = 17;
    localparam int          EVPD_ST_IPEND_BIT     = 18;
    localparam int          EVPD_ST_WAKE_BIT      = 19;
    localparam int          EVPD_ST_SPUR_BIT      = 20;

    localparam logic [15:0] EVPD_VEC_RESET        = 16'h0000;
    localparam logic [31:0] EVPD_WORD_ZERO        = 32'h0000_0000;

    typedef struct packed {
        logic                      rst_por;
        logic                      rst_clkmon;
        logic                      rst_wdog;
        logic                      trap;
        logic                      software_interrupt_request;
        logic                      debug_req;
        logic                      nmi_pin;
        logic                      d2d_err;
        logic                      irq_pin;
        logic                      d2d_int;
        logic                      top_en;
        logic [EVPD_I_DEV_NUM-1:0] i_req;
        logic [EVPD_I_DEV_NUM-1:0] i_en;
    } evpd_req_type;

    typedef struct packed {
        logic ibit;
        logic xbit;
        logic debug_active;
        logic vec_req;
        logic wait_mode;
        logic stop_mode;
    } evpd_cpu_type;

endpackage : evpd_pkg

// ---- logic/evpd_decoder.sv ----
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/10ps

// Summary of operation
// RULE1 - base is register byte over zero byte
// RULE2 - spurious vector at base plus 0x80
// RULE3 - maskable vectors from 0x82 to 0xF2
// RULE4 - x vector at 0xF4, source selectable
// RULE5 - software interrupt or debug at 0xF6
// RULE6 - opcode trap vector at base plus 0xF8
// RULE7 - reset vectors FFFE, FFFC, FFFA by cause
// RULE8 - base register resets to 0xFF
// RULE9 - reset vectors ignore programmed base
// RULE10 - debug active forces upper byte 0xFF
// RULE11 - highest vector address wins
// RULE12 - maskable needs enable, clear mask, no higher
// RULE13 - non-maskable outrank maskable, x preempts
// RULE14 - select vector only at cpu request
// RULE15 - nothing pending gives spurious vector
// RULE16 - sources hold request until service starts
// RULE17 - wake cpu with clock gated off
// RULE18 - top maskable slot at 0xF2, then descending
// RULE19 - base register readable, writable anytime
// RULE20 - set i mask blocks maskable wake
// RULE21 - x request wakes always, stop async only
// RULE22 - vector registered at strobe, held stable
module evpd_decoder (
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                arst_n,
    // exception sources
    input  wire evpd_pkg::evpd_req_type req,
    // cpu side
    input  wire evpd_pkg::evpd_cpu_type cpu,
    output logic [15:0]              vector,
    output logic                     vector_ack,
    output logic                     wakeup,
    // ahb-lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata
);
    import evpd_pkg::*;

    typedef struct packed {
        logic [7:0]  vbr;
        logic [15:0] vec;
        logic        ack;
        logic        seen;
        logic        spur;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] rdata;
    } evpd_state_type;

    evpd_state_type               st_q;
    evpd_state_type               st_d;

    logic [EVPD_I_NUM-1:0]        i_pend;
    logic                         top_src;
    logic                         x_src;
    logic                         x_pend;
    logic                         nonmask_pend;
    logic                         i_allowed;
    logic [6:0]                   i_pick;
    logic [7:0]                   base_hi;
    logic [15:0]                  vec_sel;
    logic                         vec_spur;
    logic                         wake_i;
    logic                         wake_x;
    logic                         bus_take;
    logic [31:0]                  status_word;
    logic [63:0]                  pend_word;

    // highest set index plus found flag in bit 6
    function automatic logic [6:0] evpd_top_index(input logic [EVPD_I_NUM-1:0] v);
        logic [6:0] r;
        r = 7'h00;
        for (int k = 0; k < EVPD_I_NUM; k++) begin
            if (v[k]) begin
                r = {1'b1, 6'(k)};
            end
        end
        return r;
    endfunction : evpd_top_index

    // low byte of a maskable slot
    function automatic logic [7:0] evpd_i_low(input logic [5:0] idx);
        return 8'(EVPD_VEC_I_BASE_OFS + {1'b0, idx, 1'b0});
    endfunction : evpd_i_low

    // word offset match, upper address bits alias
    function automatic logic evpd_hit(input logic [7:0] a, input logic [7:0] ofs);
        return (a[7:2] == ofs[7:2]);
    endfunction : evpd_hit

    // any maskable source qualifies for wake in wait mode; stop mode uses the top slot only
    function automatic logic evpd_any(input logic [EVPD_I_NUM-1:0] v);
        return |v;
    endfunction : evpd_any

    // source selection by die-to-die presence
    // RULE4 - x source select
    assign x_src   = EVPD_HAS_D2D ? req.d2d_err : req.nmi_pin;
    // RULE18 - top slot source
    assign top_src = (EVPD_HAS_D2D ? req.d2d_int : req.irq_pin) & req.top_en;

    // peripheral-local enables gate each device source
    // RULE12 - local enable gating
    genvar g;
    generate
        for (g = 0; g < EVPD_I_DEV_NUM; g++) begin : g_slot
            // slot g owns low byte 0x82 + 2g; its enable lives in the peripheral
            assign i_pend[g] = req.i_req[g] & req.i_en[g];
        end
    endgenerate

    // top slot sits above every device slot, so it takes the highest index
    assign i_pend[EVPD_I_NUM-1] = top_src;

    // x counts as pending only with its mask clear
    // a masked x still wakes the core but never claims the vector
    // RULE13 - x preempts maskable
    assign x_pend = x_src & ~cpu.xbit;

    assign nonmask_pend = req.trap | req.software_interrupt_request | req.debug_req | x_pend;

    // RULE12 - mask bit and higher pending block
    assign i_allowed = ~cpu.ibit & ~nonmask_pend;

    // RULE11 - highest index wins
    // RULE18 - descending low byte order
    assign i_pick = evpd_top_index(i_pend);

    // RULE10 - debug overrides base
    // RULE1 - base page upper byte
    assign base_hi = cpu.debug_active ? EVPD_VBR_DEBUG : st_q.vbr;

    // priority chain evaluated live, latched only on request
    // limitation: a source that drops before the strobe yields the spurious slot
    always_comb begin
        vec_spur = 1'b0;
        // RULE7 - reset causes first
        // RULE9 - reset vectors fixed
        if (req.rst_por) begin
            vec_sel = EVPD_VEC_RST_POR;
        end else if (req.rst_clkmon) begin
            vec_sel = EVPD_VEC_RST_CLKMON;
        end else if (req.rst_wdog) begin
            vec_sel = EVPD_VEC_RST_WDOG;
        // RULE6 - trap vector
        end else if (req.trap) begin
            vec_sel = {base_hi, EVPD_VEC_TRAP_OFS};
        // RULE5 - software or debug vector
        end else if (req.software_interrupt_request | req.debug_req) begin
            vec_sel = {base_hi, EVPD_VEC_SWI_OFS};
        // RULE4 - x maskable vector
        end else if (x_pend) begin
            vec_sel = {base_hi, EVPD_VEC_X_OFS};
        // RULE3 - maskable vector range
        end else if (i_allowed && i_pick[6]) begin
            vec_sel = {base_hi, evpd_i_low(i_pick[5:0])};
        end else begin
            // RULE15 - spurious default
            // RULE2 - spurious offset
            vec_sel  = {base_hi, EVPD_VEC_SPURIOUS_OFS};
            vec_spur = 1'b1;
        end
    end

    // wake paths are combinational: the clock is off when they matter
    // RULE20 - mask blocks maskable wake
    // RULE17 - wake without clock
    always_comb begin
        if (cpu.ibit) begin
            wake_i = 1'b0;
        end else if (cpu.stop_mode) begin
            // only the top slot is asserted asynchronously
            wake_i = top_src;
        end else if (cpu.wait_mode) begin
            wake_i = evpd_any(i_pend);
        end else begin
            wake_i = 1'b0;
        end
    end

    // RULE21 - x wakes regardless of mask
    assign wake_x = x_src & (cpu.stop_mode | cpu.wait_mode);

    assign wakeup = wake_i | wake_x;

    // register read views
    always_comb begin
        status_word = EVPD_WORD_ZERO;
        status_word[EVPD_ST_VEC_LSB +: 16] = st_q.vec;
        status_word[EVPD_ST_SEEN_BIT]      = st_q.seen;
        status_word[EVPD_ST_DEBUG_BIT]     = cpu.debug_active;
        status_word[EVPD_ST_IPEND_BIT]     = evpd_any(i_pend);
        status_word[EVPD_ST_WAKE_BIT]      = wakeup;
        status_word[EVPD_ST_SPUR_BIT]      = st_q.spur;
    end

    assign pend_word = {{(64 - EVPD_I_NUM){1'b0}}, i_pend};

    assign bus_take = hsel & hready & htrans[1];

    always_comb begin
        st_d     = st_q;
        st_d.ack = 1'b0;

        // data phase of a pending write
        // RULE19 - base writable anytime
        if (st_q.wr_pend && evpd_hit(st_q.wr_addr, EVPD_ADDR_VBR)) begin
            st_d.vbr = hwdata[7:0];
        end

        // address phase
        st_d.wr_pend = bus_take & hwrite;
        st_d.wr_addr = haddr[7:0];
        st_d.rdata   = EVPD_WORD_ZERO;
        if (bus_take && !hwrite) begin
            // RULE19 - base readable anytime
            if (evpd_hit(haddr[7:0], EVPD_ADDR_VBR)) begin
                // forward a write that completes in this same cycle
                if (st_q.wr_pend && evpd_hit(st_q.wr_addr, EVPD_ADDR_VBR)) begin
                    st_d.rdata = {24'h00_0000, hwdata[7:0]};
                end else begin
                    st_d.rdata = {24'h00_0000, st_q.vbr};
                end
            end else if (evpd_hit(haddr[7:0], EVPD_ADDR_STATUS)) begin
                st_d.rdata = status_word;
            end else if (evpd_hit(haddr[7:0], EVPD_ADDR_PEND_LO)) begin
                st_d.rdata = pend_word[31:0];
            end else if (evpd_hit(haddr[7:0], EVPD_ADDR_PEND_HI)) begin
                st_d.rdata = pend_word[63:32];
            end else begin
                st_d.rdata = EVPD_WORD_ZERO;
            end
        end

        // vector sampled on the strobe only, so a later winner still counts
        // RULE14 - select at request
        // RULE22 - latch and hold
        if (cpu.vec_req) begin
            st_d.vec  = vec_sel;
            st_d.spur = vec_spur;
            st_d.ack  = 1'b1;
            st_d.seen = 1'b1;
        end
    end

    // RULE8 - base resets to top page
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_q.vbr     <= EVPD_VBR_RESET;
            st_q.vec     <= EVPD_VEC_RESET;
            st_q.ack     <= 1'b0;
            st_q.seen    <= 1'b0;
            st_q.spur    <= 1'b0;
            st_q.wr_pend <= 1'b0;
            st_q.wr_addr <= EVPD_ADDR_VBR;
            st_q.rdata   <= EVPD_WORD_ZERO;
        end else begin
            st_q <= st_d;
        end
    end

    assign vector     = st_q.vec;
    assign vector_ack = st_q.ack;
    assign hrdata     = st_q.rdata;
    // zero-wait slave, always okay
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;

endmodule : evpd_decoder

// ---- test/evpd_decoder_chk.sv ----
`timescale 1ns/10ps

module evpd_decoder_chk (
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   arst_n,
    // watched ports
    input  wire evpd_pkg::evpd_req_type req,
    input  wire evpd_pkg::evpd_cpu_type cpu,
    input  wire logic [15:0]            vector,
    input  wire logic                   vector_ack,
    input  wire logic                   wakeup,
    input  wire logic                   hreadyout,
    input  wire logic                   hresp
);
    import evpd_pkg::*;
    logic no_rst;
    assign no_rst = !(req.rst_por || req.rst_clkmon || req.rst_wdog);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    ack_follows_a: assert property (cpu.vec_req |=> vector_ack)
        else $error("no ack after vector request");
    ack_cause_a: assert property (vector_ack |-> $past(cpu.vec_req))
        else $error("ack without request");
    vector_hold_a: assert property (!cpu.vec_req |=> $stable(vector))
        else $error("vector moved without request");
    por_vector_a: assert property (cpu.vec_req && req.rst_por |=> vector == 16'hFFFE)
        else $error("wrong power-on vector");
    wdog_vector_a: assert property (cpu.vec_req && !req.rst_por && !req.rst_clkmon
        && req.rst_wdog |=> vector == 16'hFFFA) else $error("wrong watchdog vector");
    debug_page_a: assert property (cpu.vec_req && cpu.debug_active |=>
        vector[15:8] == 8'hFF) else $error("debug page not forced");
    trap_vector_a: assert property (cpu.vec_req && no_rst && req.trap |=>
        vector[7:0] == 8'hF8) else $error("wrong trap vector");
    idle_wake_a: assert property (!cpu.wait_mode && !cpu.stop_mode |-> !wakeup)
        else $error("wake outside low power");
    x_wake_a: assert property (cpu.wait_mode && req.d2d_err |-> wakeup)
        else $error("x request did not wake");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    cover property (cpu.vec_req && req.trap);
    cover property (cpu.vec_req && !cpu.ibit && req.d2d_int);
    cover property (cpu.stop_mode && wakeup);
endmodule : evpd_decoder_chk

bind evpd_decoder evpd_decoder_chk u_chk (.mclk(mclk), .arst_n(arst_n), .req(req), .cpu(cpu),
    .vector(vector), .vector_ack(vector_ack), .wakeup(wakeup), .hreadyout(hreadyout),
    .hresp(hresp));

// ---- test/evpd_src_model.sv ----
`timescale 1ns/10ps

module evpd_src_model (
    // clock
    input  wire logic        mclk,
    // source control
    input  wire logic [55:0] raise,
    input  wire logic [55:0] served,
    // request lines
    output logic      [55:0] lines_q
);
    initial lines_q = '0;
    always @(posedge mclk) begin
        lines_q <= (lines_q & ~served) | raise;
    end
endmodule : evpd_src_model

// ---- test/testbench.sv ----
`timescale 1ns/10ps

module testbench;
    import evpd_pkg::*;
    logic mclk = 0, arst_n = 0, hsel = 1, hwrite = 0, hready, ack, wake;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
    logic [55:0] raise = 0, served = 0, lines;
    logic [15:0] vec, last_vec;
    logic [7:0] base;
    evpd_req_type req_drv = '0, req_in;
    evpd_cpu_type cpu = '0;
    logic [15:0] expq[$];
    int mismatches = 0, n_tests = 0, i, m;

    always #2.5 mclk = ~mclk;
    always_comb begin
        req_in = req_drv;
        req_in.i_req = lines;
    end
    evpd_src_model src (.mclk(mclk), .raise(raise), .served(served), .lines_q(lines));
    evpd_decoder dut (.mclk(mclk), .arst_n(arst_n), .req(req_in), .cpu(cpu), .vector(vec),
        .vector_ack(ack), .wakeup(wake), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(), .hrdata(hrdata));

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    function automatic logic [15:0] model(input evpd_req_type r, input evpd_cpu_type c);
        logic [7:0] pg;
        pg = c.debug_active ? 8'hFF : base;
        if (r.rst_por) return 16'hFFFE;
        if (r.rst_clkmon) return 16'hFFFC;
        if (r.rst_wdog) return 16'hFFFA;
        if (r.trap) return {pg, 8'hF8};
        if (r.software_interrupt_request || r.debug_req) return {pg, 8'hF6};
        if (r.d2d_err && !c.xbit) return {pg, 8'hF4};
        if (!c.ibit && r.d2d_int && r.top_en) return {pg, 8'hF2};
        for (int k = 55; k >= 0; k--)
            if (!c.ibit && r.i_req[k] && r.i_en[k]) return {pg, 8'h82 + 8'(2 * k)};
        return {pg, 8'h80};
    endfunction : model

    task report_and_stop;
        if (mismatches == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    // scoreboard: oldest expected vector against each ack
    always @(posedge mclk) begin
        if (ack === 1'b1) begin
            last_vec = expq.pop_front();
            chk("vector", {16'h0, last_vec}, {16'h0, vec});
        end
    end

    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        report_and_stop;
    end

    initial begin
        void'($urandom(38586));
        repeat (8) @(posedge mclk);
        arst_n <= 1;
        bus(0, 32'h0, 0);
        chk("base reset", 32'hFF, rd);
        bus(0, 32'h10, 0);
        chk("unmapped", 32'h0, rd);
        for (i = 0; i < 80; i++) begin
            if (i % 20 == 0) begin
                base = 8'($urandom);
                bus(1, 32'h0, {24'h0, base});
                bus(0, 32'h0, 0);
                chk("base rw", {24'h0, base}, rd);
            end
            @(posedge mclk);
            m = $urandom % 3;
            served <= '1;
            raise <= 56'({$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom});
            req_drv <= '{rst_por: ($urandom % 12 == 0), rst_clkmon: ($urandom % 12 == 0),
                rst_wdog: ($urandom % 10 == 0), trap: ($urandom % 8 == 0),
                software_interrupt_request: ($urandom % 8 == 0), debug_req: ($urandom % 10 == 0),
                nmi_pin: 1'($urandom), d2d_err: ($urandom % 5 == 0), irq_pin: 1'($urandom),
                d2d_int: ($urandom % 4 == 0), top_en: 1'($urandom), i_req: '0,
                i_en: 56'({$urandom, $urandom})};
            cpu <= '{ibit: ($urandom % 3 == 0), xbit: 1'($urandom),
                debug_active: ($urandom % 4 == 0),
                vec_req: 0, wait_mode: (m == 1), stop_mode: (m == 2)};
            @(posedge mclk);
            served <= '0;
            raise <= '0;
            cpu.vec_req <= 1;
            #1;
            expq.push_back(model(req_in, cpu));
            chk("wakeup", (req_in.d2d_err && m != 0) || (!cpu.ibit && (m == 1 &&
                (|(lines & req_in.i_en)) || m != 0 && req_in.d2d_int && req_in.top_en)), wake);
            @(posedge mclk);
            cpu.vec_req <= 0;
            repeat (2) @(posedge mclk);
        end
        bus(0, 32'h4, 0);
        chk("status vector", {16'h0, last_vec}, {16'h0, rd[15:0]});
        report_and_stop;
    end
endmodule : testbench
